//--- logic/momsi_pkg.sv
package momsi_pkg;

  // security spaces, one feature frame each
  localparam int NUM_SPACES = 4;
  typedef enum logic [1:0]
  {
    SPACE_SECURE    = 2'h0,
    SPACE_NONSECURE = 2'h1,
    SPACE_ROOT      = 2'h2,
    SPACE_REALM     = 2'h3
  } momsi_space_type;

  // register offsets inside each feature frame
  localparam logic [11:0] OVERFLOW_MSI_LABEL_OFFSET       = 12'h8DC;
  localparam logic [11:0] OVERFLOW_MSI_PAYLOAD_OFFSET     = 12'h8E8;
  localparam logic [11:0] OVERFLOW_PENDING_SUMMARY_OFFSET = 12'h8F0;

  // label field layout
  localparam int LABEL_PARTITION_LSB = 0;
  localparam int LABEL_PARTITION_MSB = 15;
  localparam int LABEL_GROUP_LSB     = 16;
  localparam int LABEL_GROUP_MSB     = 23;

  // summary field layout
  localparam int SUMMARY_CACHE_BIT     = 31;
  localparam int SUMMARY_BANDWIDTH_BIT = 30;
  localparam int SUMMARY_RESOURCE_MSB  = 15;
  localparam int NUM_RESOURCES         = 16;

  // reset values
  localparam logic [23:0] LABEL_RESET   = 24'h000000;
  localparam logic [31:0] PAYLOAD_RESET = 32'h00000000;

  // one register access from a feature page
  typedef struct packed
  {
    logic            write;
    momsi_space_type space;
    logic [11:0]     offset;
    logic [31:0]     wdata;
  } momsi_access_type;

  // one overflow message write towards the interrupt controller
  typedef struct packed
  {
    momsi_space_type space;
    logic [31:0]     payload;
    logic [7:0]      monitoring_group;
    logic [15:0]     partition_identifier;
  } momsi_msi_type;

  // message emitter states, gray along idle -> send
  typedef enum logic [1:0]
  {
    MSI_IDLE = 2'h0,
    MSI_SEND = 2'h1
  } momsi_state_type;

endpackage

//--- logic/momsi_top.sv
`timescale 1ns/1ps
// Contract
// R1 - feature-page registers exist in all four address maps
// R2 - four independent payload words, one per security space
// R3 - payload read-write at 0x08E8; root and realm copies need realm feature
// R4 - payload is one 32-bit field sent as message write data
// R5 - 32-bit read-write label register at 0x08DC
// R6 - each space's label tags only that space's message writes
// R7 - label bits 23:16 carry the monitoring group; bits 31:24 reserved
// R8 - label bits 15:0 carry the partition identifier
// R9 - label fields reset to unknown; software programs them first; the code resets them to zero (LABEL_RESET)
// R10 - secure copy partition is secure space, non-secure copy non-secure space
// R11 - message writes only supported when all five message registers exist
// R12 - each label copy reachable only from its own space's page
// R13 - read-only 32-bit summary of monitor overflows; writes ignored
// R14 - summary at 0x08F0; root and realm copies need realm feature
// R15 - each space's summary reflects only that space's monitors
// R16 - summary bit 31 set while any cache monitor has overflow set
// R17 - cache pending clears only when every cache monitor flag is clear
// R18 - summary bit 30 set while any bandwidth monitor has either flag
// R19 - bandwidth pending clears only when all bandwidth flags are clear
// R20 - summary bit r set when resource instance r has any overflow
// R21 - reserved label and summary bits read zero, writes ignored
module momsi_top
#(
  parameter int NUM_CACHE_MONITORS     = 8,
  parameter int NUM_BANDWIDTH_MONITORS = 8,
  parameter bit REALM_PRESENT          = 1'b1,
  parameter bit MSI_SUPPORTED          = 1'b1,
  parameter bit SUMMARY_SUPPORTED      = 1'b1
)
(
  input  wire logic                                                        clk,
  input  wire logic                                                        nrst,
  input  wire logic                                                        access_valid,
  input  wire momsi_pkg::momsi_access_type                                 access,
  output logic                                                             read_valid,
  output logic [31:0]                                                      read_data,
  input  wire logic [momsi_pkg::NUM_SPACES-1:0]                            msi_enable,
  input  wire logic [momsi_pkg::NUM_SPACES-1:0]                            overflow_event,
  input  wire logic [momsi_pkg::NUM_SPACES-1:0][NUM_CACHE_MONITORS-1:0]     cache_overflow_flag,
  input  wire logic [momsi_pkg::NUM_SPACES-1:0][NUM_BANDWIDTH_MONITORS-1:0] bandwidth_overflow_flag,
  input  wire logic [momsi_pkg::NUM_SPACES-1:0][NUM_BANDWIDTH_MONITORS-1:0] long_counter_overflow_flag,
  input  wire logic [momsi_pkg::NUM_SPACES-1:0][momsi_pkg::NUM_RESOURCES-1:0] resource_overflow_flag,
  output logic                                                             msi_valid,
  input  wire logic                                                        msi_accept,
  output momsi_pkg::momsi_msi_type                                         msi_write
);
  import momsi_pkg::*;

  // per-space register copies
  logic [NUM_SPACES-1:0][31:0] payload;
  logic [NUM_SPACES-1:0][23:0] label;
  logic [NUM_SPACES-1:0][31:0] summary_word;
  logic [NUM_SPACES-1:0]       pending;
  logic [NUM_SPACES-1:0]       next_pending;
  logic [NUM_SPACES-1:0]       served;
  logic [31:0]                 next_read_data;
  logic                        access_ok;
  logic                        msi_capable;
  momsi_state_type             state;
  momsi_space_type             sel_space;
  // write strobes and the emitter's launch decision
  logic [NUM_SPACES-1:0]       payload_we;
  logic [NUM_SPACES-1:0]       label_we;
  logic                        launch;
  momsi_space_type             next_space;

  // root and realm frames only exist with the realm feature
  function automatic logic space_present(input momsi_space_type s);
    begin
      space_present = ((s == SPACE_ROOT) || (s == SPACE_REALM)) ? REALM_PRESENT : 1'b1;
    end
  endfunction

  // lowest numbered space with a pending overflow message
  function automatic momsi_space_type first_pending(input logic [NUM_SPACES-1:0] p);
    begin
      first_pending = SPACE_SECURE;
      for (int i = NUM_SPACES - 1; i >= 0; i--)
      begin
        if (p[i])
        begin
          first_pending = momsi_space_type'(i[1:0]);
        end
      end
    end
  endfunction

  // write hit on one register; shared by both write strobes so the
  // payload and label copies can never disagree on what counts as a write
  function automatic logic write_hit(input momsi_access_type a, input logic [11:0] off);
    begin
      write_hit = a.write && (a.offset == off);
    end
  endfunction

  // message registers only mean something as a complete set
  assign msi_capable = MSI_SUPPORTED;  // see R11

  // absent frames answer zero and ignore writes; reads still get an answer
  // so a stray access from software never stalls the register port
  assign access_ok = access_valid && space_present(access.space);  // see R1 see R3 see R14

  // summary per space from that space's own monitor flags only
  generate
    for (genvar s = 0; s < NUM_SPACES; s++)
    begin : g_summary
      logic        cache_any;
      logic        bandwidth_any;
      logic [31:0] word;
      // reduction holds the bit while any single flag remains set
      assign cache_any     = |cache_overflow_flag[s];  // see R16 see R17
      assign bandwidth_any = |(bandwidth_overflow_flag[s] | long_counter_overflow_flag[s]);  // see R18 see R19
      // fields placed by position; reserved bits stay zero
      always_comb
      begin
        word                         = 32'h00000000;  // see R21
        word[SUMMARY_CACHE_BIT]      = cache_any;
        word[SUMMARY_BANDWIDTH_BIT]  = bandwidth_any;
        word[SUMMARY_RESOURCE_MSB:0] = resource_overflow_flag[s];  // see R20
      end
      // live view, not sticky: software sees a bit drop as soon as the
      // last contributing flag clears, with no separate acknowledge
      assign summary_word[s] = SUMMARY_SUPPORTED ? word : 32'h00000000;  // see R15
    end
  endgenerate

  // one write strobe per copy; a frame only ever reaches its own space,
  // so one space's software cannot relabel another space's messages
  always_comb
  begin
    payload_we = '0;
    label_we   = '0;
    if (access_ok && msi_capable)
    begin
      payload_we[access.space] = write_hit(access, OVERFLOW_MSI_PAYLOAD_OFFSET);  // see R2 see R3
      label_we[access.space]   = write_hit(access, OVERFLOW_MSI_LABEL_OFFSET);  // see R5 see R12
    end
  end

  // payload copies, one per space
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int s = 0; s < NUM_SPACES; s++)
      begin
        payload[s] <= PAYLOAD_RESET;
      end
    end
    else
    begin
      for (int s = 0; s < NUM_SPACES; s++)
      begin
        if (payload_we[s])
        begin
          payload[s] <= access.wdata;  // see R4
        end
      end
    end
  end

  // label copies; reserved top byte is never stored, so it reads back zero
  // without a mask in the read mux
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int s = 0; s < NUM_SPACES; s++)
      begin
        label[s] <= LABEL_RESET;  // see R9
      end
    end
    else
    begin
      for (int s = 0; s < NUM_SPACES; s++)
      begin
        if (label_we[s])
        begin
          label[s] <= access.wdata[LABEL_GROUP_MSB:LABEL_PARTITION_LSB];  // see R21
        end
      end
    end
  end

  // read mux; unmapped or absent offsets read zero, summary ignores writes
  always_comb
  begin
    next_read_data = 32'h00000000;
    if (access_ok)
    begin
      case (access.offset)
        OVERFLOW_MSI_PAYLOAD_OFFSET:
        begin
          next_read_data = msi_capable ? payload[access.space] : 32'h00000000;
        end
        OVERFLOW_MSI_LABEL_OFFSET:
        begin
          next_read_data = msi_capable ? {8'h00, label[access.space]} : 32'h00000000;  // see R7 see R21
        end
        OVERFLOW_PENDING_SUMMARY_OFFSET:
        begin
          next_read_data = summary_word[access.space];  // see R13
        end
        default:
        begin
          next_read_data = 32'h00000000;
        end
      endcase
    end
  end

  // every read gets an answer one cycle later, even to absent frames
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      read_valid <= 1'b0;
      read_data  <= 32'h00000000;
    end
    else
    begin
      read_valid <= access_valid && !access.write;
      read_data  <= next_read_data;
    end
  end

  // a new event in the same cycle as a send beats the clear
  always_comb
  begin
    served = '0;
    if (state == MSI_SEND && msi_accept)
    begin
      served[sel_space] = 1'b1;
    end
    next_pending = (pending & ~served) | (overflow_event & msi_enable);
    if (!msi_capable)
    begin
      next_pending = '0;
    end
  end

  // pending message per space
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pending <= '0;
    end
    else
    begin
      pending <= next_pending;
    end
  end

  // launch decision shared by every emitter register; fixed priority means
  // a busy low space can delay higher ones, traded for a tiny arbiter
  assign launch     = (state == MSI_IDLE) && (|pending);
  assign next_space = first_pending(pending);

  // emitter sequencing: one write at a time, held until the controller
  // accepts; there is no timeout, a dead controller stalls all spaces
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= MSI_IDLE;
    end
    else
    begin
      case (state)
        MSI_IDLE:
        begin
          if (launch)
          begin
            state <= MSI_SEND;
          end
        end
        MSI_SEND:
        begin
          if (msi_accept)
          begin
            state <= MSI_IDLE;
          end
        end
        default:
        begin
          state <= MSI_IDLE;
        end
      endcase
    end
  end

  // offer flag set at launch, dropped on the accepting edge; kept in its own
  // flop so the pin never sees decode glitches from the state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      msi_valid <= 1'b0;
    end
    else if (launch)
    begin
      msi_valid <= 1'b1;
    end
    else if (state == MSI_SEND && msi_accept)
    begin
      msi_valid <= 1'b0;
    end
  end

  // space of the offer in flight, used to clear the right pending bit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_space <= SPACE_SECURE;
    end
    else if (launch)
    begin
      sel_space <= next_space;
    end
  end

  // fields captured at launch and frozen while the offer stands, so a
  // register write during a stall cannot change a message already offered
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      msi_write <= '0;
    end
    else if (launch)
    begin
      msi_write.space                <= next_space;  // see R10
      msi_write.payload              <= payload[next_space];  // see R4
      msi_write.monitoring_group     <= label[next_space][LABEL_GROUP_MSB:LABEL_GROUP_LSB];  // see R6 see R7
      msi_write.partition_identifier <= label[next_space][LABEL_PARTITION_MSB:LABEL_PARTITION_LSB];  // see R8
    end
  end

endmodule

//--- verif/momsi_sva.sv
`timescale 1ns/1ps
module momsi_sva
  import momsi_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          nrst,
  input wire logic                          access_valid,
  input wire momsi_access_type              access,
  input wire logic                          read_valid,
  input wire logic [31:0]                   read_data,
  input wire logic [3:0]                    msi_enable,
  input wire logic [3:0]                    overflow_event,
  input wire logic [3:0][NUM_RESOURCES-1:0] resource_overflow_flag,
  input wire logic                          msi_valid,
  input wire logic                          msi_accept,
  input wire momsi_msi_type                 msi_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // register port answers
  chk_read_answer: assert property (access_valid && !access.write |=> read_valid)
    else $error("read not answered");
  chk_write_silent: assert property (access_valid && access.write |=> !read_valid)
    else $error("write answered");
  chk_label_reserved: assert property (read_valid && $past(access.offset) == OVERFLOW_MSI_LABEL_OFFSET |-> read_data[31:24] == 8'h00)
    else $error("label top byte not zero");
  chk_summary_reserved: assert property (read_valid && $past(access.offset) == OVERFLOW_PENDING_SUMMARY_OFFSET |-> read_data[29:16] == 14'h0)
    else $error("summary reserved bits set");
  chk_summary_resource: assert property (read_valid && $past(access.offset) == OVERFLOW_PENDING_SUMMARY_OFFSET |-> read_data[15:0] == $past(resource_overflow_flag[access.space]))
    else $error("summary resource bits wrong");
  // message handshake: offer stands until taken
  chk_msi_hold: assert property (msi_valid && !msi_accept |=> msi_valid && $stable(msi_write))
    else $error("message dropped or changed");
  chk_msi_release: assert property (msi_valid && msi_accept |=> !msi_valid)
    else $error("message not released");
  chk_event_launch: assert property (overflow_event[0] && msi_enable[0] && !msi_valid |-> ##[1:2] msi_valid)
    else $error("message not launched");
endmodule

//--- verif/momsi_ctrl_model.sv
`timescale 1ns/1ps
module momsi_ctrl_model
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic msi_valid,
  output logic      msi_accept
);
  logic [1:0] wait_count;
  // slow mode stalls each write three cycles, like a busy controller
  assign msi_accept = msi_valid && (!slow || wait_count == 2'h3);
  // stall counter restarts after every taken write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wait_count <= 2'h0;
    else if (!msi_valid || msi_accept)
      wait_count <= 2'h0;
    else
      wait_count <= wait_count + 2'h1;
  end
endmodule

//--- verif/momsi_top_tb.sv
`timescale 1ns/1ps
module momsi_top_tb;
  import momsi_pkg::*;
  logic             clk;
  logic             nrst;
  logic             access_valid;
  momsi_access_type access;
  logic             read_valid;
  logic [31:0]      read_data;
  logic [3:0]       msi_enable;
  logic [3:0]       overflow_event;
  logic [3:0][7:0]  cache_flag;
  logic [3:0][7:0]  bw_flag;
  logic [3:0][7:0]  long_flag;
  logic [3:0][15:0] res_flag;
  logic             msi_valid;
  logic             msi_accept;
  logic             slow;
  momsi_msi_type    msi_write;
  momsi_msi_type    got[$];
  int               err_count = 0;
  int               total_checks = 0;
  int               cycles = 0;
  int               sp[4] = '{0, 1, 3, 2};
  logic [31:0]      c_tab[3] = '{32'h00000081, 32'h40000001, 32'h0};
  logic [31:0]      b_tab[3] = '{32'h00001000, 32'h0, 32'h0};
  logic [31:0]      l_tab[3] = '{32'h0, 32'h00000400, 32'h0};

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  momsi_top u_dut(.clk(clk), .nrst(nrst), .access_valid(access_valid), .access(access), .read_valid(read_valid),
    .read_data(read_data), .msi_enable(msi_enable), .overflow_event(overflow_event), .cache_overflow_flag(cache_flag),
    .bandwidth_overflow_flag(bw_flag), .long_counter_overflow_flag(long_flag), .resource_overflow_flag(res_flag),
    .msi_valid(msi_valid), .msi_accept(msi_accept), .msi_write(msi_write));
  momsi_ctrl_model u_ctrl(.clk(clk), .nrst(nrst), .slow(slow), .msi_valid(msi_valid), .msi_accept(msi_accept));

  // log taken writes; cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (msi_valid && msi_accept)
      got.push_back(msi_write);
    if (cycles == 3000)
    begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [31:0] pay(input int s);
    return 32'hCAFE0000 + s;
  endfunction
  function automatic logic [31:0] lab(input int s);
    return 32'h0010BE00 + s * 32'h00010001;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one access; a read is checked 1 ns after the clock edge that takes it
  task automatic acc(input logic w, input int s, input logic [11:0] off, input logic [31:0] d);
    @(posedge clk);
    access_valid <= 1'b1;
    access <= '{w, momsi_space_type'(s[1:0]), off, d};
    @(posedge clk);
    access_valid <= 1'b0;
    #1;
    if (!w)
      check({read_valid, read_data}, {1'b1, d});
  endtask

  initial
  begin
    nrst = 1'b0;
    access_valid = 1'b0;
    access = '0;
    msi_enable = 4'h0;
    overflow_event = 4'h0;
    cache_flag = '0;
    bw_flag = '0;
    long_flag = '0;
    res_flag = '0;
    slow = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // per-space copies, reserved label byte, read-only summary, unmapped hole
    for (int s = 0; s < 4; s++)
    begin
      acc(1'b0, s, OVERFLOW_MSI_PAYLOAD_OFFSET, PAYLOAD_RESET);
      acc(1'b1, s, OVERFLOW_MSI_PAYLOAD_OFFSET, pay(s));
      acc(1'b1, s, OVERFLOW_MSI_LABEL_OFFSET, 32'hFF000000 | lab(s));
      acc(1'b1, s, OVERFLOW_PENDING_SUMMARY_OFFSET, 32'hFFFFFFFF);
    end
    for (int s = 0; s < 4; s++)
    begin
      acc(1'b0, s, OVERFLOW_MSI_PAYLOAD_OFFSET, pay(s));
      acc(1'b0, s, OVERFLOW_MSI_LABEL_OFFSET, lab(s));
      acc(1'b0, s, 12'h8E4, 32'h0);
    end
    $display("test 1 done");
    // summary tracks flags per space, pending holds while any flag stays
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      cache_flag <= c_tab[k];
      bw_flag <= b_tab[k];
      long_flag <= l_tab[k];
      res_flag <= 64'h800140022004100F >> k;
      @(posedge clk);
      for (int s = 0; s < 4; s++)
        acc(1'b0, s, OVERFLOW_PENDING_SUMMARY_OFFSET, {|cache_flag[s], |{bw_flag[s], long_flag[s]}, 14'h0, res_flag[s]});
    end
    $display("test 2 done");
    // stalled controller, disabled space, merged repeat, then prompt accept
    @(posedge clk);
    msi_enable <= 4'hB;
    slow <= 1'b1;
    overflow_event <= 4'hF;
    @(posedge clk);
    overflow_event <= 4'h2;
    @(posedge clk);
    overflow_event <= 4'h0;
    repeat (30) @(posedge clk);
    slow <= 1'b0;
    msi_enable <= 4'hF;
    overflow_event <= 4'h4;
    @(posedge clk);
    overflow_event <= 4'h0;
    repeat (10) @(posedge clk);
    check(got.size(), 4);
    for (int i = 0; i < 4; i++)
      check(got[i], {momsi_space_type'(sp[i][1:0]), pay(sp[i]), 24'(lab(sp[i]))});
    $display("test 3 done");
    final_report();
  end
endmodule

bind momsi_top momsi_sva u_sva(.clk(clk), .nrst(nrst), .access_valid(access_valid), .access(access),
  .read_valid(read_valid), .read_data(read_data), .msi_enable(msi_enable), .overflow_event(overflow_event),
  .resource_overflow_flag(resource_overflow_flag), .msi_valid(msi_valid), .msi_accept(msi_accept), .msi_write(msi_write));
